// *** sim/emb_link_asserts.sv ***
`timescale 1ns/100ps
module emb_link_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic [27:0] addr,
  input wire logic rd_wr,
  input wire logic [1:0] xfer_size,
  input wire logic xfer_start_n,
  input wire logic data_m_oe,
  input wire logic xfer_ack_n_o,
  input wire logic xfer_ack_n_oe,
  input wire logic ack_line_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_start_pulse: assert property (!xfer_start_n |=> xfer_start_n)
    else $error("start strobe held too long");
  a_no_early_ack: assert property (!xfer_start_n |=> ack_line_n)
    else $error("ack without the decode cycle");
  a_size_long: assert property (!xfer_start_n |-> xfer_size == 2'h0)
    else $error("start with non-longword size");
  a_no_overlap: assert property (!xfer_start_n |-> !xfer_ack_n_oe)
    else $error("new start before ack released");
  a_rw_hold: assert property (xfer_ack_n_oe && $past(xfer_ack_n_oe)
    |-> $stable(rd_wr)) else $error("direction changed in burst");
  a_addr_step: assert property ($changed(addr) && xfer_ack_n_oe &&
    $past(xfer_ack_n_oe) |-> addr == $past(addr) + 28'h000_0001)
    else $error("address step is not one");
  a_wdata_on: assert property (!ack_line_n && !rd_wr |-> data_m_oe)
    else $error("write acked without data driven");
  a_release: assert property ($fell(xfer_ack_n_oe) |-> $past(xfer_ack_n_o))
    else $error("ack released while asserted");
  a_burst_ends: assert property ($rose(xfer_ack_n_oe)
    |-> ##[1:600] !xfer_ack_n_oe) else $error("burst never ends");
endmodule // emb_link_asserts

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] cs_reg = 6'h00, dm_reg = 6'h00;
  logic [4:0] beats = 5'h02;
  logic hreadyout, hresp, busy;
  int fails = 0, compares = 0, n;
  emb_link_if lnk ();
  always #50 hclk = ~hclk;
  emb_dev emb_dev_i (.hclk(hclk), .hresetn(hresetn), .chipsel_ctrl_reg(cs_reg),
    .default_mem_ctrl_reg(dm_reg), .burst_beats(beats), .link(lnk),
    .busy(busy));
  emb_mst emb_mst_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hready(hreadyout), .link(lnk));
  emb_link_asserts emb_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .addr(lnk.addr), .rd_wr(lnk.rd_wr), .xfer_size(lnk.xfer_size),
    .xfer_start_n(lnk.xfer_start_n), .data_m_oe(lnk.data_m_oe),
    .xfer_ack_n_o(lnk.xfer_ack_n_o), .xfer_ack_n_oe(lnk.xfer_ack_n_oe),
    .ack_line_n(lnk.ack_line_n));
  // slave side: byte tied to address, toggling garbage when not selected
  initial begin
    lnk.data_s = 32'h0000_0000;
    lnk.data_s_oe = 1'b0;
  end
  always @(posedge hclk) begin
    lnk.data_s_oe <= lnk.xfer_ack_n_oe & lnk.rd_wr;
    lnk.data_s <= (lnk.xfer_ack_n_oe & lnk.rd_wr) ?
      {lnk.addr[7:0] ^ 8'h5A, 24'h00_0000} : ~lnk.data_s;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= emb_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // latency to first ack, acked beats, and negated cycles while driven
  task automatic watch(input int ws, input int nb);
    int k, g;
    k = 0;
    g = 0;
    n = 0;
    do begin @(negedge hclk); n++; end
    while (lnk.xfer_start_n !== 1'b0 && n < 50);
    n = 0;
    do begin @(negedge hclk); n++; end
    while (lnk.ack_line_n !== 1'b0 && n < 50);
    chk(n, ws + 2);
    while (lnk.xfer_ack_n_oe === 1'b1 && k + g < 400) begin
      if (lnk.ack_line_n === 1'b0) k++;
      else g++;
      @(negedge hclk);
    end
    chk(k, nb);
    chk(g, (nb - 1) * ws + 1);
  endtask
  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  initial begin
    #500_000;
    fails++;
    wrap_up();
  end
  initial begin
    do_reset();
    dm_reg <= 6'h30;
    beats <= 5'h10;
    for (int i = 0; i < 16; i++) ahb(1'b1, emb_pkg::REG_WDATA, 32'hC0DE_0000 + i);
    ahb(1'b0, emb_pkg::REG_STAT, 32'h0000_0000);
    chk(r[2], 1'b0);
    ahb(1'b1, emb_pkg::REG_ADDR, 32'h0000_0100);
    ahb(1'b1, emb_pkg::REG_CMD, 32'h0000_0100);
    watch(0, 16);
    dm_reg <= 6'h33;
    beats <= 5'h04;
    ahb(1'b1, emb_pkg::REG_ADDR, 32'h0000_0200);
    ahb(1'b1, emb_pkg::REG_CMD, 32'h0000_0041);
    watch(3, 4);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, emb_pkg::REG_RDATA, 32'h0000_0000);
      chk(r[7:0], i[7:0] ^ 8'h5A);
    end
    // chip select without auto-ack: nobody terminates, so reset after
    cs_reg <= 6'h21;
    beats <= 5'h02;
    ahb(1'b1, emb_pkg::REG_ADDR, 32'h0100_0000);
    ahb(1'b1, emb_pkg::REG_CMD, 32'h0000_0021);
    n = 0;
    repeat (40) begin
      @(negedge hclk);
      if (lnk.ack_line_n !== 1'b1) n++;
    end
    chk(n, 0);
    chk(busy, 1'b0);
    do_reset();
    cs_reg <= 6'h31;
    for (int i = 0; i < 2; i++) ahb(1'b1, emb_pkg::REG_WDATA, 32'hBEEF_0000 + i);
    ahb(1'b1, emb_pkg::REG_ADDR, 32'h0100_0010);
    ahb(1'b1, emb_pkg::REG_CMD, 32'h0000_0020);
    watch(1, 2);
    wrap_up();
  end
endmodule // tb

// *** verilog/emb_dev.sv ***
`timescale 1ns/100ps
// Overview of operation
// - one extra clock before wait counter starts
// - master steps address after each acknowledge
// - no burst to burst-disabled space (the device ignores CTRL_BURST_BIT and runs burst_beats beats, clamped to two to sixteen)
// - burst is two to sixteen beats
// - master drives address, direction, size, start
// - device registers address, direction, size
// - decode, pick wait count if enabled
// - master drops start, drives write data
// - zero waits: acknowledge at third cycle
// - ack negated while waits remain
// - master waits until acknowledge seen
// - 8-bit read bytes from top lane
// - 8-bit port address plus one per byte
// - zero waits: ack held across beats
// - ack inactive after last, then released
// - chip-select ack only when enabled there
module emb_dev (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory-space configuration
  input wire logic [5:0] chipsel_ctrl_reg,
  input wire logic [5:0] default_mem_ctrl_reg,
  input wire logic [4:0] burst_beats,
  // link
  emb_link_if.dev link,
  // status
  output logic busy
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_BEAT = 2'b10,
    ST_RELEASE = 2'b11
  } emb_dst_t;
  typedef struct packed {
    emb_dst_t st;
    logic [27:0] addr;
    logic rd_wr;
    logic [1:0] size;
    logic [3:0] ws;
    logic [3:0] ws_load;
    logic [4:0] left;
    logic ack_n;
    logic ack_oe;
  } emb_dev_st_t;
  emb_dev_st_t s_q, s_d;
  logic [5:0] ctrl;
  logic [4:0] beats;
  always_comb begin
    s_d = s_q;
    ctrl = (s_q.addr[emb_pkg::REGION_MSB:emb_pkg::REGION_LSB]
            == emb_pkg::CS_REGION) ? chipsel_ctrl_reg
                                   : default_mem_ctrl_reg;
    beats = burst_beats;
    if (beats < emb_pkg::BEATS_MIN) beats = emb_pkg::BEATS_MIN;
    if (beats > emb_pkg::BEATS_MAX) beats = emb_pkg::BEATS_MAX;
    s_d.ack_n = 1'b1;
    case (s_q.st)
      ST_IDLE: begin
        s_d.ack_oe = 1'b0;
        if (!link.xfer_start_n) begin
          s_d.addr = link.addr;
          s_d.rd_wr = link.rd_wr;
          s_d.size = link.xfer_size;
          s_d.left = beats;
          s_d.st = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // only terminate when auto-ack is enabled for the decoded space
        if (ctrl[emb_pkg::CTRL_AUTO_ACK_BIT]) begin
          s_d.ws_load = ctrl[3:0];
          s_d.ws = ctrl[3:0];
          s_d.ack_oe = 1'b1;
          s_d.ack_n = ctrl[3:0] != 4'h0;
          s_d.st = ST_BEAT;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      ST_BEAT: begin
        if (!s_q.ack_n) begin
          s_d.left = s_q.left - 5'h01;
          if (s_q.left == 5'h01) begin
            s_d.st = ST_RELEASE;
          end else begin
            s_d.ws = s_q.ws_load;
            s_d.ack_n = s_q.ws_load != 4'h0;
          end
        end else begin
          s_d.ws = s_q.ws - 4'h1;
          s_d.ack_n = s_q.ws != 4'h1;
        end
      end
      ST_RELEASE: begin
        s_d.ack_oe = 1'b0;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: ST_IDLE, ack_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  assign link.xfer_ack_n_o = s_q.ack_n;
  assign link.xfer_ack_n_oe = s_q.ack_oe;
  assign busy = s_q.st != ST_IDLE;
endmodule // emb_dev

// *** verilog/emb_fifo.sv ***
`timescale 1ns/100ps
module emb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } emb_fifo_st_t;
  emb_fifo_st_t s_q, s_d;
  logic push, pop;
  assign in_ready = s_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop) s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge hclk) begin
    if (push) mem[s_q.wp] <= in_data;
  end
endmodule // emb_fifo

// *** verilog/emb_link_if.sv ***
`timescale 1ns/100ps
interface emb_link_if;
  logic [27:0] addr;
  logic rd_wr;
  logic [1:0] xfer_size;
  logic xfer_start_n;
  logic [31:0] data_m;
  logic data_m_oe;
  logic [31:0] data_s;
  logic data_s_oe;
  logic xfer_ack_n_o;
  logic xfer_ack_n_oe;
  wire ack_line_n = xfer_ack_n_oe ? xfer_ack_n_o : 1'b1;
  modport dev (
    input addr, rd_wr, xfer_size, xfer_start_n,
    output xfer_ack_n_o, xfer_ack_n_oe
  );
  modport mst (
    output addr, rd_wr, xfer_size, xfer_start_n, data_m, data_m_oe,
    input data_s, data_s_oe, ack_line_n
  );
endinterface

// *** verilog/emb_mst.sv ***
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
module emb_mst (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hready,
  // link
  emb_link_if.mst link
);
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_START = 2'b01,
    MS_WAIT = 2'b10
  } emb_mst_st_enum_t;
  typedef struct packed {
    emb_mst_st_enum_t st;
    logic ph_v;
    logic ph_w;
    logic [7:0] ph_a;
    logic [27:0] addr;
    logic rd_wr;
    logic [4:0] left;
    logic [4:0] beats;
    logic [31:0] wdata;
    logic done;
    logic [1:0] ack_s;
  } emb_mst_st_t;
  emb_mst_st_t s_q, s_d;
  logic rx_valid, rx_ready, tx_valid, tx_ready, tx_push;
  logic [31:0] rx_data, tx_data;
  logic acc, ack_seen, rd_pop;
  assign acc = hsel && hready && htrans == emb_pkg::HTRANS_NONSEQ;
  assign ack_seen = !s_q.ack_s[1];
  assign rd_pop = s_q.ph_v && !s_q.ph_w && s_q.ph_a == emb_pkg::REG_RDATA;
  assign tx_push = s_q.ph_v && s_q.ph_w && s_q.ph_a == emb_pkg::REG_WDATA;
  // stall a write to REG_WDATA while the write FIFO is full
  assign hreadyout = !(tx_push && !tx_ready);
  assign hresp = 1'b0;
  always_comb begin
    s_d = s_q;
    s_d.ack_s = {s_q.ack_s[0], link.ack_line_n};
    s_d.done = 1'b0;
    if (hreadyout) begin
      s_d.ph_v = acc;
      s_d.ph_w = hwrite;
      s_d.ph_a = haddr[7:0];
    end
    if (s_q.ph_v && s_q.ph_w && hreadyout) begin
      if (s_q.ph_a == emb_pkg::REG_ADDR) s_d.addr = hwdata[27:0];
      if (s_q.ph_a == emb_pkg::REG_CMD && s_q.st == MS_IDLE) begin
        s_d.rd_wr = hwdata[0];
        s_d.beats = hwdata[8:4];
        s_d.left = hwdata[8:4];
        s_d.st = MS_START;
      end
    end
    case (s_q.st)
      MS_IDLE: ;
      MS_START: begin
        s_d.st = MS_WAIT;
        if (!s_q.rd_wr) s_d.wdata = tx_data;
      end
      MS_WAIT: begin
        if (ack_seen) begin
          s_d.addr = s_q.addr + emb_pkg::ADDR_STEP;
          s_d.left = s_q.left - 5'h01;
          if (!s_q.rd_wr) s_d.wdata = tx_data;
          if (s_q.left == 5'h01) begin
            s_d.st = MS_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      default: s_d.st = MS_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: MS_IDLE, ack_s: 2'b11, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      if (acc && !hwrite) begin
        case (haddr[7:0])
          emb_pkg::REG_RDATA: hrdata <= rx_data;
          emb_pkg::REG_STAT:
            hrdata <= {24'h0000_00, 2'b00, s_q.st, 1'b0,
                       tx_ready, rx_valid, s_q.st != MS_IDLE};
          emb_pkg::REG_ADDR: hrdata <= {4'h0, s_q.addr};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // read path: sampled top lane per beat (8-bit port)
  emb_fifo #(.WIDTH(32), .DEPTH(emb_pkg::FIFO_DEPTH)) u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(s_q.st == MS_WAIT && ack_seen && s_q.rd_wr),
    .in_ready(rx_ready),
    .in_data({24'h0000_00, link.data_s[31:24]}),
    .out_valid(rx_valid),
    .out_ready(rd_pop),
    .out_data(rx_data)
  );
  emb_fifo #(.WIDTH(32), .DEPTH(emb_pkg::FIFO_DEPTH)) u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(tx_push),
    .in_ready(tx_ready),
    .in_data(hwdata),
    .out_valid(tx_valid),
    .out_ready((s_q.st == MS_START || (s_q.st == MS_WAIT && ack_seen))
               && !s_q.rd_wr),
    .out_data(tx_data)
  );
  assign link.addr = s_q.addr;
  assign link.rd_wr = s_q.rd_wr;
  assign link.xfer_size = emb_pkg::SIZE_LONG;
  assign link.xfer_start_n = s_q.st != MS_START;
  assign link.data_m = s_q.wdata;
  assign link.data_m_oe = s_q.st == MS_WAIT && !s_q.rd_wr;
endmodule // emb_mst

// *** verilog/emb_pkg.sv ***
package emb_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int WS_W = 4;
  localparam int BEAT_W = 5;
  // a burst is between two and sixteen beats long
  localparam logic [4:0] BEATS_MIN = 5'h02;
  localparam logic [4:0] BEATS_MAX = 5'h10;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam int FIFO_DEPTH = 16;
  // address step per beat for an 8-bit port
  localparam logic [27:0] ADDR_STEP = 28'h000_0001;
  // chip-select window: addresses with this top nibble go to a chip select
  localparam logic [3:0] CS_REGION = 4'h1;
  localparam int REGION_MSB = 27;
  localparam int REGION_LSB = 24;
  // AHB-Lite map of the master's command/status registers
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // device control fields
  localparam int CTRL_BURST_BIT = 5;
  localparam int CTRL_AUTO_ACK_BIT = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
endpackage
